// file: tb/fault_source.sv
// Trip comparators of the power stage
`timescale 1ns/100ps
module fault_source (
  input  wire logic  clk,
  output logic       thermal_trip,
  output logic [7:0] overcurrent_trip
);
  initial {thermal_trip, overcurrent_trip} = '0;
  task automatic fault(input logic th, input logic [7:0] oc, input int n);
    @(posedge clk) #1 {thermal_trip, overcurrent_trip} = {th, oc};
    repeat (n) @(posedge clk);
    #1 {thermal_trip, overcurrent_trip} = '0;
  endtask : fault
endmodule : fault_source

// file: tb/prot_asserts.sv
// Checker of shutdown timing and status
`timescale 1ns/100ps
module prot_asserts
  import bridge_protect_pkg::*;
#(
  parameter int NUM_T       = 8,
  parameter int HOLD_CYCLES = 20,
  parameter int GLITCH_CYC  = 5
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             thermal_trip,
  input wire logic [NUM_T-1:0] overcurrent_trip,
  input wire logic             bridges_enable,
  input wire logic             protection_status_out,
  input wire prot_status_t     status
);
  localparam int HM1 = HOLD_CYCLES - 1;
  int run_reg;
  int run_next;
  // Raw run length; sync delay is covered by the margin
  always_comb run_next = |overcurrent_trip ? run_reg + 1 : 0;
  always_ff @(posedge clk) run_reg <= run_next;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_th; $rose(thermal_trip) && bridges_enable |-> ##[1:4] !bridges_enable; endproperty
  property p_hold; $fell(bridges_enable) |-> ##HM1 !bridges_enable ##1 bridges_enable; endproperty
  property p_cause; $fell(bridges_enable) |-> $past(thermal_trip, 2) || $past(thermal_trip, 3)
    || run_reg > GLITCH_CYC || $past(run_reg, 3) > GLITCH_CYC; endproperty
  property p_cld; protection_status_out == !bridges_enable; endproperty
  property p_st; status.protection_status_out == protection_status_out
    && status.bridges_enabled == bridges_enable; endproperty
  property p_src; status.protection_status_out
    == (status.thermal_active || status.overcurrent_active); endproperty
  property p_retry; $rose(bridges_enable) && run_reg > HOLD_CYCLES |-> ##[1:3] !bridges_enable;
  endproperty
  property p_ocf; $rose(status.overcurrent_active) |-> $past(run_reg, 2) >= GLITCH_CYC;
  endproperty
  a_th: assert property (p_th) else $error("no thermal shutdown");
  a_hold: assert property (p_hold) else $error("wrong hold length");
  a_cause: assert property (p_cause) else $error("shutdown without cause");
  a_cld: assert property (p_cld) else $error("status out wrong");
  a_st: assert property (p_st) else $error("status struct wrong");
  a_src: assert property (p_src) else $error("status source wrong");
  a_retry: assert property (p_retry) else $error("no retry");
  a_ocf: assert property (p_ocf) else $error("early overcurrent");
  c_fall: cover property ($fell(bridges_enable));
  c_rise: cover property ($rose(bridges_enable));
  c_retry: cover property ($rose(bridges_enable) ##1 !bridges_enable);
endmodule : prot_asserts
bind motor_bridge_protection_fsm prot_asserts #(.NUM_T(NUM_T), .HOLD_CYCLES(HOLD_CYCLES),
  .GLITCH_CYC(GLITCH_CYC)) prot_asserts_i (.clk, .reset, .thermal_trip, .overcurrent_trip,
  .bridges_enable, .protection_status_out, .status);

// file: tb/test_motor_bridge_protection_fsm.sv
// Self-checking bench for the bridge protection sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module test_motor_bridge_protection_fsm
  import bridge_protect_pkg::*;
;
  localparam int HOLD = 20;
  localparam int GLT  = 5;
  logic         clk = 0;
  logic         reset = 1;
  logic         thermal_trip;
  logic [7:0]   overcurrent_trip;
  logic         bridges_enable;
  logic         protection_status_out;
  prot_status_t status;
  int           n_mismatch = 0;
  int           n_compared = 0;
  int           n;
  always #5 clk = ~clk;
  fault_source fault_source_i (.clk, .thermal_trip, .overcurrent_trip);
  motor_bridge_protection_fsm #(.HOLD_CYCLES(HOLD), .GLITCH_CYC(GLT))
    motor_bridge_protection_fsm_i (.clk, .reset, .thermal_trip, .overcurrent_trip,
    .bridges_enable, .protection_status_out, .status);
  task automatic off_len(output int len);
    len = 0;
    repeat (40) if (bridges_enable) @(posedge clk) #2;
    while (!bridges_enable && len < 99) begin
      `CHK(protection_status_out, 1'b1)
      len++;
      @(posedge clk) #2;
    end
  endtask : off_len
  task automatic t_thermal;
    fork fault_source_i.fault(1'b1, 8'h00, 2); join_none
    off_len(n);
    `CHK(n, HOLD)
    `CHK(status, 4'b1000)
    $display("thermal done");
  endtask : t_thermal
  task automatic t_glitch;
    fork fault_source_i.fault(1'b0, 8'hff, GLT - 1); join_none
    repeat (30) begin
      @(posedge clk) #2;
      `CHK(bridges_enable, 1'b1)
    end
    $display("glitch done");
  endtask : t_glitch
  task automatic t_oc;
    for (int i = 0; i < 8; i++) begin
      fork fault_source_i.fault(1'b0, 8'h01 << i, GLT + 8); join_none
      off_len(n);
      `CHK(n, HOLD)
    end
    $display("overcurrent done");
  endtask : t_oc
  task automatic t_retry;
    fork fault_source_i.fault(1'b0, 8'h80, 70); join_none
    off_len(n);
    `CHK(n, HOLD)
    off_len(n);
    `CHK(n, HOLD)
    repeat (80) @(posedge clk);
    $display("retry done");
  endtask : t_retry
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    // Trip sources stay quiet while reset holds the bridges enabled
    repeat (8) @(posedge clk);
    #1 reset = 0;
    #1 `CHK(status, 4'b1000)
    t_thermal;
    t_glitch;
    t_oc;
    t_retry;
    end_of_test;
  end
  initial begin
    #20us;
    n_mismatch++;
    end_of_test;
  end
endmodule : test_motor_bridge_protection_fsm

// file: verilog/bridge_protect_params.svh
// Timing and width constants for the bridge protection sequencer
`ifndef BRIDGE_PROTECT_PARAMS_SVH
`define BRIDGE_PROTECT_PARAMS_SVH
`define CLK_PERIOD_NS       10
`define HOLD_OFF_TIME_NS    50000
`define GLITCH_TIME_NS      10000
`define HOLD_OFF_CYCLES     (`HOLD_OFF_TIME_NS / `CLK_PERIOD_NS)
`define GLITCH_CYCLES       ((`GLITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NUM_TRANSISTORS     8
`define COUNT_WIDTH         16
`endif

// file: verilog/bridge_protect_pkg.sv
// Types shared by the bridge protection sequencer
package bridge_protect_pkg;
  typedef enum logic [1:0] {
    PROT_RUN,
    PROT_HOLD
  } prot_state_t;

  typedef struct packed {
    logic bridges_enabled;
    logic thermal_active;
    logic overcurrent_active;
    logic protection_status_out;
  } prot_status_t;
endpackage : bridge_protect_pkg

// file: verilog/motor_bridge_protection_fsm.sv
// Fault protection sequencer gating all output transistors of both bridges
// Overview of operation
// - Thermal trip switches every output transistor off
// - Thermal off-time 50 us, then automatic re-enable
// - Any single transistor overcurrent turns all off
// - Overcurrent hold 50 us, then automatic re-enable
// - Repeated overcurrent repeats cycle without retry limit
// - Overcurrent acted on only after 10 us persistence
// - Status high while limiter or thermal shutdown active
`timescale 1ns/100ps
`include "bridge_protect_params.svh"
module motor_bridge_protection_fsm
  import bridge_protect_pkg::*;
#(
  parameter int NUM_T       = `NUM_TRANSISTORS,
  parameter int CW          = `COUNT_WIDTH,
  parameter int HOLD_CYCLES = `HOLD_OFF_CYCLES,
  parameter int GLITCH_CYC  = `GLITCH_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             thermal_trip,
  input  wire logic [NUM_T-1:0] overcurrent_trip,
  output logic                  bridges_enable,
  output logic                  protection_status_out,
  output prot_status_t          status
);
  logic [NUM_T-1:0] oc_confirmed;
  logic             thermal_sync;
  logic             oc_any;

  // One filter per transistor, each watched on its own
  for (genvar i = 0; i < NUM_T; i++) begin : g_oc
    trip_sync_filter #(
      .CW         (CW),
      .MIN_CYCLES (GLITCH_CYC)
    ) u_filt (
      .clk            (clk),
      .reset          (reset),
      .trip_async     (overcurrent_trip[i]),
      .trip_sync      (),
      .trip_confirmed (oc_confirmed[i])
    );
  end

  // Thermal trip needs no glitch filter, only a synchroniser
  trip_sync_filter #(
    .CW         (CW),
    .MIN_CYCLES (1)
  ) u_therm (
    .clk            (clk),
    .reset          (reset),
    .trip_async     (thermal_trip),
    .trip_sync      (thermal_sync),
    .trip_confirmed ()
  );

  assign oc_any = |oc_confirmed;

  prot_state_t   state_reg, state_next;
  logic [CW-1:0] hold_reg,  hold_next;
  logic          therm_reg, therm_next;
  logic          oc_reg,    oc_next;
  logic          en_reg,    en_next;
  logic          stat_reg,  stat_next;

  always_comb begin
    state_next = state_reg;
    hold_next  = hold_reg;
    therm_next = therm_reg;
    oc_next    = oc_reg;
    unique case (state_reg)
      PROT_RUN: begin
        if (thermal_sync || oc_any) begin
          state_next = PROT_HOLD;
          hold_next  = CW'(HOLD_CYCLES - 1);
          therm_next = thermal_sync;
          oc_next    = oc_any;
        end
      end
      PROT_HOLD: begin
        // Late trips during hold are recorded but do not restart the timer
        therm_next = therm_reg | thermal_sync;
        oc_next    = oc_reg | oc_any;
        if (hold_reg == '0) begin
          state_next = PROT_RUN;
          therm_next = 1'b0;
          oc_next    = 1'b0;
        end else begin
          hold_next = hold_reg - CW'(1);
        end
      end
    endcase
    en_next   = (state_next == PROT_RUN);
    stat_next = therm_next | oc_next;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= PROT_RUN;
      hold_reg  <= '0;
      therm_reg <= 1'b0;
      oc_reg    <= 1'b0;
      en_reg    <= 1'b1;
      stat_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_reg  <= hold_next;
      therm_reg <= therm_next;
      oc_reg    <= oc_next;
      en_reg    <= en_next;
      stat_reg  <= stat_next;
    end
  end

  // Enabled out of reset; power-up safety is left to the controller
  assign bridges_enable        = en_reg;
  assign protection_status_out = stat_reg;
  assign status = '{bridges_enabled:       en_reg,
                    thermal_active:        therm_reg,
                    overcurrent_active:    oc_reg,
                    protection_status_out: stat_reg};
endmodule : motor_bridge_protection_fsm

// file: verilog/trip_sync_filter.sv
// Two-stage synchroniser followed by a persistence filter for one trip input
`timescale 1ns/100ps
`include "bridge_protect_params.svh"
module trip_sync_filter #(
  parameter int CW         = `COUNT_WIDTH,
  parameter int MIN_CYCLES = `GLITCH_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic trip_async,
  output logic      trip_sync,
  output logic      trip_confirmed
);
  logic          meta_reg, meta_next;
  logic          sync_reg, sync_next;
  logic [CW-1:0] run_reg,  run_next;
  logic          conf_reg, conf_next;

  always_comb begin
    meta_next = trip_async;
    sync_next = meta_reg;
    run_next  = run_reg;
    conf_next = conf_reg;
    if (!sync_reg) begin
      // Any dropout restarts the persistence count
      run_next  = '0;
      conf_next = 1'b0;
    end else if (run_reg < CW'(MIN_CYCLES - 1)) begin
      run_next = run_reg + CW'(1);
    end else begin
      conf_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      run_reg  <= '0;
      conf_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      run_reg  <= run_next;
      conf_reg <= conf_next;
    end
  end

  assign trip_sync      = sync_reg;
  assign trip_confirmed = conf_reg;
endmodule : trip_sync_filter
